/* src/arcc_pkg.sv */
// package: register map, field positions, reset values and states for the rx clock/channel config
package arcc_pkg;

    localparam logic [7:0]  ADDR_CLOCK_CFG    = 8'h88;
    localparam logic [7:0]  ADDR_CHANNEL_CFG  = 8'h8c;
    localparam logic [7:0]  ADDR_FRAME_CFG    = 8'h90;
    localparam logic [7:0]  ADDR_CONTROL      = 8'h94;
    localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h98;
    localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h9c;

    localparam int          MASTER_CLOCK_SOURCE_SELECT_LSB          = 26;
    localparam int          BCP_BIT           = 25;
    localparam int          BCD_BIT           = 24;
    localparam int          DIV_LSB           = 0;
    localparam int          DIV_W             = 8;
    localparam int          RCE_BIT           = 16;
    localparam int          WFL_BIT           = 0;
    localparam int          FRAME_WORD_COUNT_BIT          = 16;
    localparam int          RE_BIT            = 31;
    localparam int          WORD_BITS_LSB     = 0;
    localparam int          WORD_BITS_W       = 5;

    localparam logic [1:0]  MASTER_CLOCK_SOURCE_SELECT_BUS          = 2'h0;
    localparam logic [1:0]  MASTER_CLOCK_SOURCE_SELECT_MCLK1        = 2'h1;
    localparam logic [1:0]  MASTER_CLOCK_SOURCE_SELECT_MCLK2        = 2'h2;
    localparam logic [1:0]  MASTER_CLOCK_SOURCE_SELECT_MCLK3        = 2'h3;

    localparam logic [31:0] CLOCK_CFG_RST     = 32'h0000_0000;
    localparam logic [4:0]  WORD_BITS_RST     = 5'h1f;

    localparam int          IRQ_W             = 2;
    localparam int          IRQ_SOW_BIT       = 0;
    localparam int          IRQ_FRAME_BIT     = 1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_STOP  = 3'b100
    } arcc_state_e;

endpackage : arcc_pkg

/* src/arcc_bclk_gen.sv */
// file: bit clock divider, toggles every div+1 ticks of the selected master clock
`timescale 1ns/10ps
module arcc_bclk_gen
    import arcc_pkg::*;
#(
    parameter int DW = DIV_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    input  wire logic          run_i,
    input  wire logic          mclk_tick_i,
    input  wire logic [DW-1:0] div_i,
    output logic               bclk_o,
    output logic               rise_o,
    output logic               fall_o
);

    logic [DW-1:0] count;

    // count div+1 ticks per half period, so a full period is (div+1)*2
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && !run_i)) begin
            count  <= '0;
            bclk_o <= 1'b0;
        end else if (ce_i && mclk_tick_i) begin
            if (count == div_i) begin
                count  <= '0;
                bclk_o <= ~bclk_o;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    assign rise_o = ce_i && run_i && mclk_tick_i && (count == div_i) && !bclk_o;
    assign fall_o = ce_i && run_i && mclk_tick_i && (count == div_i) && bclk_o;

    a_half_period_len: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && run_i && mclk_tick_i && count != div_i && $stable(div_i))
        |=> !$changed(bclk_o))
        else $error("bit clock toggled before div+1 ticks");

endmodule : arcc_bclk_gen

/* src/arcc_rx_cfg.sv */
// file: receive clock/channel configuration block with wishbone registers
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
module arcc_rx_cfg
    import arcc_pkg::*;
#(
    parameter int WBITS_MAX = 32
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic [2:0]  mclk_tick_i,
    input  wire logic        ext_bclk_i,
    input  wire logic        rx_data_i,
    output logic             bclk_o,
    output logic             bclk_oe_o,
    output logic             rx_word_o,
    output logic             rx_word_valid_o,
    output logic             start_of_word_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0]  mclk_sel;
    logic        bclk_pol;
    logic        bclk_dir;
    logic [7:0]  bclk_div;
    logic        rx_channel_enable;
    logic        word_flag_select;
    logic        frame_word_count;
    logic [4:0]  word_bits;
    logic        receiver_enable;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic        req;
    logic        wr;
    logic        hit;
    logic [31:0] wmask;
    logic [31:0] next_rdata;
    arcc_state_e state;
    logic        sel_tick;
    logic        gen_rise;
    logic        gen_fall;
    logic        ext_q;
    logic        ext_rise;
    logic        ext_fall;
    logic        drive_edge;
    logic        sample_edge;
    logic [4:0]  bit_cnt;
    logic        word_cnt;
    logic [31:0] shift;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit = (wb_adr_i == ADDR_CLOCK_CFG) || (wb_adr_i == ADDR_CHANNEL_CFG)
              || (wb_adr_i == ADDR_FRAME_CFG) || (wb_adr_i == ADDR_CONTROL)
              || (wb_adr_i == ADDR_IRQ_STATUS) || (wb_adr_i == ADDR_IRQ_MASK);
    assign wr  = ce_i && req && wb_we_i && hit;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack or err in the cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            wb_dat_o <= (req && hit && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_CLOCK_CFG: begin
                next_rdata[MASTER_CLOCK_SOURCE_SELECT_LSB +: 2]     = mclk_sel;
                next_rdata[BCP_BIT]           = bclk_pol;
                next_rdata[BCD_BIT]           = bclk_dir;
                next_rdata[DIV_LSB +: DIV_W]  = bclk_div;
            end
            ADDR_CHANNEL_CFG: begin
                next_rdata[RCE_BIT] = rx_channel_enable;
                next_rdata[WFL_BIT] = word_flag_select;
            end
            ADDR_FRAME_CFG: begin
                next_rdata[FRAME_WORD_COUNT_BIT]                  = frame_word_count;
                next_rdata[WORD_BITS_LSB +: WORD_BITS_W] = word_bits;
            end
            ADDR_CONTROL:    next_rdata[RE_BIT] = receiver_enable;
            ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
            ADDR_IRQ_MASK:   next_rdata[IRQ_W-1:0] = irq_mask;
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers; only documented fields store, reserved bits drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mclk_sel <= CLOCK_CFG_RST[MASTER_CLOCK_SOURCE_SELECT_LSB +: 2];
            bclk_pol <= CLOCK_CFG_RST[BCP_BIT];
            bclk_dir <= CLOCK_CFG_RST[BCD_BIT];
            bclk_div <= CLOCK_CFG_RST[DIV_LSB +: DIV_W];
        end else if (wr && wb_adr_i == ADDR_CLOCK_CFG) begin
            if (wmask[MASTER_CLOCK_SOURCE_SELECT_LSB]) begin
                mclk_sel <= wb_dat_i[MASTER_CLOCK_SOURCE_SELECT_LSB +: 2];
                bclk_pol <= wb_dat_i[BCP_BIT];
                bclk_dir <= wb_dat_i[BCD_BIT];
            end
            if (wmask[DIV_LSB]) begin
                bclk_div <= wb_dat_i[DIV_LSB +: DIV_W];
            end
        end
    end

    // software is trusted not to rewrite this while the receiver runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_channel_enable <= 1'b0;
            word_flag_select  <= 1'b0;
        end else if (wr && wb_adr_i == ADDR_CHANNEL_CFG) begin
            if (wmask[RCE_BIT]) rx_channel_enable <= wb_dat_i[RCE_BIT];
            if (wmask[WFL_BIT]) word_flag_select  <= wb_dat_i[WFL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_word_count <= 1'b0;
            word_bits        <= WORD_BITS_RST;
            receiver_enable  <= 1'b0;
        end else if (wr) begin
            if (wb_adr_i == ADDR_FRAME_CFG && wmask[FRAME_WORD_COUNT_BIT]) begin
                frame_word_count <= wb_dat_i[FRAME_WORD_COUNT_BIT];
            end
            if (wb_adr_i == ADDR_FRAME_CFG && wmask[WORD_BITS_LSB]) begin
                word_bits <= wb_dat_i[WORD_BITS_LSB +: WORD_BITS_W];
            end
            if (wb_adr_i == ADDR_CONTROL && wmask[RE_BIT]) begin
                receiver_enable <= wb_dat_i[RE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
            irq_mask   <= '0;
        end else if (ce_i) begin
            if (wr && wb_adr_i == ADDR_IRQ_MASK && wmask[0]) begin
                irq_mask <= wb_dat_i[IRQ_W-1:0];
            end
            if (wr && wb_adr_i == ADDR_IRQ_STATUS && wmask[0]) begin
                irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // clock source: the select only matters in master mode
    always_comb begin
        case (mclk_sel)
            MASTER_CLOCK_SOURCE_SELECT_BUS:   sel_tick = 1'b1;
            MASTER_CLOCK_SOURCE_SELECT_MCLK1: sel_tick = mclk_tick_i[0];
            MASTER_CLOCK_SOURCE_SELECT_MCLK2: sel_tick = mclk_tick_i[1];
            MASTER_CLOCK_SOURCE_SELECT_MCLK3: sel_tick = mclk_tick_i[2];
            default:    sel_tick = 1'b0;
        endcase
    end

    arcc_bclk_gen #(
        .DW (DIV_W)
    ) u_gen (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .run_i       (bclk_dir && state == ST_RUN),
        .mclk_tick_i (sel_tick),
        .div_i       (bclk_div),
        .bclk_o      (bclk_o),
        .rise_o      (gen_rise),
        .fall_o      (gen_fall)
    );

    assign bclk_oe_o = bclk_dir && state == ST_RUN;

    // external clock is taken as synchronous; edges found by one delay stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_q <= 1'b0;
        end else if (ce_i) begin
            ext_q <= ext_bclk_i;
        end
    end

    assign ext_rise = ce_i && !bclk_dir && ext_bclk_i && !ext_q;
    assign ext_fall = ce_i && !bclk_dir && !ext_bclk_i && ext_q;

    // polarity 0: sample on falling edge; polarity 1: sample on rising edge
    assign sample_edge = bclk_pol ? (gen_rise | ext_rise) : (gen_fall | ext_fall);
    assign drive_edge  = bclk_pol ? (gen_fall | ext_fall) : (gen_rise | ext_rise);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else if (ce_i) begin
            case (state)
                ST_IDLE: if (receiver_enable && rx_channel_enable) state <= ST_RUN;
                ST_RUN:  if (!receiver_enable || !rx_channel_enable) state <= ST_STOP;
                ST_STOP: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // word framing; the flag is raised on the drive edge starting word flag+1
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && state != ST_RUN)) begin
            bit_cnt  <= 5'h00;
            word_cnt <= 1'b0;
            shift    <= 32'h0000_0000;
        end else if (sample_edge) begin
            shift <= {shift[30:0], rx_data_i};
            if (bit_cnt == word_bits) begin
                bit_cnt  <= 5'h00;
                word_cnt <= (word_cnt == frame_word_count) ? 1'b0 : ~word_cnt;
            end else begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_of_word_o <= 1'b0;
            rx_word_valid_o <= 1'b0;
            rx_word_o       <= 1'b0;
        end else if (ce_i) begin
            start_of_word_o <= state == ST_RUN && drive_edge && bit_cnt == 5'h00
                            && word_cnt == word_flag_select
                            && word_flag_select <= frame_word_count;
            rx_word_valid_o <= state == ST_RUN && sample_edge && bit_cnt == word_bits;
            rx_word_o       <= shift[0];
        end
    end

    assign irq_event[IRQ_SOW_BIT]   = ce_i && start_of_word_o;
    assign irq_event[IRQ_FRAME_BIT] = ce_i && rx_word_valid_o && word_cnt == 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    a_flag_above_frame: assert property (@(posedge clk_i) disable iff (rst_i)
        (word_flag_select && !frame_word_count) |=> !start_of_word_o)
        else $error("start-of-word flag raised beyond frame size");

    a_slave_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        !bclk_dir |-> !bclk_oe_o)
        else $error("bit clock driven in slave mode");

    a_channel_gates_run: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && state == ST_IDLE && !rx_channel_enable) |=> state == ST_IDLE)
        else $error("receiver started with channel disabled");

    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && $past(wb_adr_i) == ADDR_CLOCK_CFG) |-> wb_dat_o[23:8] == 16'h0000)
        else $error("reserved clock bits not zero");

    a_pol_sample: assert property (@(posedge clk_i) disable iff (rst_i)
        (!bclk_pol && gen_rise) |-> !sample_edge)
        else $error("sampled on rising edge with polarity 0");

    a_pol_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (bclk_pol && gen_rise) |-> !drive_edge)
        else $error("drove on rising edge with polarity 1");

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    a_select_bus_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        mclk_sel == MASTER_CLOCK_SOURCE_SELECT_BUS |-> sel_tick)
        else $error("bus clock select does not tick every cycle");

    a_unmapped_err: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && !hit) |=> wb_err_o)
        else $error("unmapped address not answered with err");

    a_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o))
        else $error("ack and err raised together");

    a_status_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && irq_event[IRQ_SOW_BIT]) |=> irq_status[IRQ_SOW_BIT])
        else $error("start-of-word status lost to a clear");

    a_master_rise_pol0: assert property (@(posedge clk_i) disable iff (rst_i)
        (bclk_dir && !bclk_pol && drive_edge) |=> bclk_o)
        else $error("polarity 0 drive edge is not a rising bit clock");

    a_master_fall_pol1: assert property (@(posedge clk_i) disable iff (rst_i)
        (bclk_dir && bclk_pol && drive_edge) |=> !bclk_o)
        else $error("polarity 1 drive edge is not a falling bit clock");

    a_enable_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> ($stable(state) && $stable(wb_ack_o) && $stable(bclk_o)))
        else $error("state moved while clock enable low");

    a_stop_to_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && state == ST_STOP) |=> state == ST_IDLE)
        else $error("stop state not followed by idle");

    a_idle_no_valid: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && state != ST_RUN) |=> !rx_word_valid_o)
        else $error("word valid while receiver not running");

endmodule : arcc_rx_cfg

/* bench/arcc_codec_model.sv */
// external codec model: supplies the bit clock and serial data in slave mode
`timescale 1ns/10ps
module arcc_codec_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [7:0] half_i,
    input  wire logic       pol_i,
    output logic            bclk_o,
    output logic            data_o
);
    logic [7:0]  cnt;
    logic [15:0] pat;
    ////////////////////////////////////////////////////////////////////////
    // clock stands still low outside a run, as a gated codec clock would
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt    <= 8'h00;
            bclk_o <= 1'b0;
        end else if (cnt == half_i - 8'h01) begin
            cnt    <= 8'h00;
            bclk_o <= ~bclk_o;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // new bit on the drive edge, so it is settled by the sample edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pat    <= 16'h4d2b;
            data_o <= 1'b0;
        end else if (!run_i) begin
            data_o <= ~data_o;
        end else if (bclk_o == pol_i && cnt == half_i - 8'h01) begin
            pat    <= {pat[14:0], pat[15]};
            data_o <= pat[15];
        end
    end
endmodule : arcc_codec_model

/* bench/arcc_rx_cfg_tb.sv */
// testbench: wishbone register tests, clock divider, word flag and slave mode
`timescale 1ns/10ps
module arcc_rx_cfg_tb;
    import arcc_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, codec_run;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, wb_dat_o, q;
    logic        wb_ack_o, wb_err_o, ext_bclk, rx_data, e, lv, ce, spol, eq, sb, sd;
    logic        bclk_o, bclk_oe_o, rx_word_o, rx_word_valid_o, start_of_word_o, irq_o;
    logic [2:0]  tick = 3'h0;
    int          tcnt = 0, cycles = 0, bad_count = 0, n_tests = 0, h, g;
    int          sp[4] = '{1, 2, 3, 4};
    int          pol_t[5] = '{0, 1, 0, 0, 0};
    int          fz_t[5] = '{0, 0, 1, 1, 0};
    int          fl_t[5] = '{0, 0, 1, 0, 1};
    int          gap_t[5] = '{32, 32, 64, 64, 400};

    arcc_rx_cfg arcc_rx_cfg_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .mclk_tick_i(tick),
        .ext_bclk_i(ext_bclk), .rx_data_i(rx_data), .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o),
        .rx_word_o(rx_word_o), .rx_word_valid_o(rx_word_valid_o),
        .start_of_word_o(start_of_word_o), .irq_o(irq_o));
    arcc_codec_model arcc_codec_model_i (.clk_i(clk_i), .rst_i(rst_i), .run_i(codec_run),
        .half_i(8'h03), .pol_i(spol), .bclk_o(ext_bclk), .data_o(rx_data));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    // master clock options 1..3 tick every 2, 3 and 4 bus clocks
    always_ff @(posedge clk_i) begin
        tcnt <= (tcnt == 11) ? 0 : tcnt + 1;
        tick <= {tcnt % 4 == 3, tcnt % 3 == 2, tcnt % 2 == 1};
    end
    // expected received bit: wire level at the codec sample edge, two clocks on
    always_ff @(posedge clk_i) begin
        eq <= ext_bclk;
        if (eq !== ext_bclk && ext_bclk === spol) sb <= rx_data;
        sd <= sb;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic chk32(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk32
    task automatic chk_n(input string nm, input int ex, input int got);
        n_tests++;
        if (got != ex) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, ex, got);
        end
    endtask : chk_n
    // one classic cycle; read data and err taken at the edge that shows ack or err
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rq, output logic re);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        rq = wb_dat_o;
        re = wb_err_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 20) chk_n("wishbone answer", 1, 0);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic        re;
        xfer(1'b1, a, d, rq, re);
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex,
                      input logic [31:0] m = 32'hffff_ffff);
        logic [31:0] rq;
        logic        re;
        xfer(1'b0, a, 32'h0, rq, re);
        chk32(nm, ex, rq & m);
    endtask : rd
    // receiver is stopped before any configuration write
    task automatic setup(input logic [1:0] ms, input logic pol, input logic dir,
                         input logic [7:0] dv, input logic fz, input logic fl, input logic ch);
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_CLOCK_CFG, {4'h0, ms, pol, dir, 16'h0000, dv});
        wr(ADDR_FRAME_CFG, {15'h0, fz, 11'h0, 5'h03});
        wr(ADDR_CHANNEL_CFG, {15'h0, ch, 15'h0, fl});
        wr(ADDR_CONTROL, 32'h8000_0000);
    endtask : setup
    task automatic half(output int hv);
        logic b;
        int   n;
        n = 0;
        b = bclk_o;
        while (bclk_o === b && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        b = bclk_o;
        hv = 0;
        while (bclk_o === b && hv < 200) begin
            @(posedge clk_i);
            hv++;
        end
    endtask : half
    task automatic gap(output int gv, output logic lvl, input bit vw);
        int n;
        n = 0;
        while ((vw ? rx_word_valid_o : start_of_word_o) !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
        gv = 1;
        while ((vw ? rx_word_valid_o : start_of_word_o) !== 1'b1 && gv < 400) begin
            @(posedge clk_i);
            gv++;
        end
        lvl = bclk_o;
    endtask : gap
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        codec_run = 1'b0;
        ce = 1'b1;
        spol = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("clock cfg reset", ADDR_CLOCK_CFG, CLOCK_CFG_RST);
        rd("channel cfg reset", ADDR_CHANNEL_CFG, 32'h0);
        rd("frame cfg reset", ADDR_FRAME_CFG, {27'h0, WORD_BITS_RST});
        wr(ADDR_CLOCK_CFG, 32'hffff_ffff);
        rd("clock cfg reserved", ADDR_CLOCK_CFG, 32'h0f00_00ff);
        wr(ADDR_CHANNEL_CFG, 32'hffff_ffff);
        rd("channel cfg reserved", ADDR_CHANNEL_CFG, 32'h0001_0001);
        xfer(1'b0, 8'h00, 32'h0, q, e);
        chk32("unmapped err", 32'h1, {31'h0, e});
        chk32("unmapped data", 32'h0, q);
        // receiver on but channel off: nothing may run
        setup(MASTER_CLOCK_SOURCE_SELECT_BUS, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0, 1'b0);
        half(h);
        chk_n("bclk with channel off", 200, h);
        chk32("oe with channel off", 32'h0, {31'h0, bclk_oe_o});
        for (int c = 0; c < 4; c++) begin
            setup(2'(c), 1'b0, 1'b1, 8'h02, 1'b0, 1'b0, 1'b1);
            half(h);
            chk_n("bclk half period", 3 * sp[c], h);
            chk32("oe in master", 32'h1, {31'h0, bclk_oe_o});
        end
        // 4-bit words, half bit 4 clocks: one word lasts 32 clocks
        for (int i = 0; i < 5; i++) begin
            setup(MASTER_CLOCK_SOURCE_SELECT_BUS, 1'(pol_t[i]), 1'b1, 8'h03, 1'(fz_t[i]), 1'(fl_t[i]), 1'b1);
            gap(g, lv, 1'b0);
            chk_n("start flag spacing", gap_t[i], g);
            if (i < 4) chk32("bclk at start flag", 32'(1 - pol_t[i]), {31'h0, lv});
        end
        // clock enable low holds the bit clock, which otherwise toggles every 4 clocks
        ce <= 1'b0;
        repeat (2) @(posedge clk_i);
        lv = bclk_o;
        repeat (4) @(posedge clk_i);
        chk32("bclk frozen", {31'h0, lv}, {31'h0, bclk_o});
        ce <= 1'b1;
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0);
        rd("sow status set", ADDR_IRQ_STATUS, 32'h1, 32'h1);
        chk32("irq masked", 32'h0, {31'h0, irq_o});
        wr(ADDR_IRQ_MASK, 32'h1);
        chk32("irq unmasked", 32'h1, {31'h0, irq_o});
        wr(ADDR_IRQ_STATUS, 32'h3);
        chk32("irq cleared", 32'h0, {31'h0, irq_o});
        rd("sow status cleared", ADDR_IRQ_STATUS, 32'h0, 32'h3);
        // slave: codec half bit 3 clocks, word 24 clocks with source bus or mclk3
        codec_run <= 1'b1;
        for (int c = 0; c < 4; c += 3) begin
            spol <= (c == 3);
            setup(2'(c), (c == 3), 1'b0, 8'h05, 1'b0, 1'b0, 1'b1);
            chk32("oe in slave", 32'h0, {31'h0, bclk_oe_o});
            gap(g, lv, 1'b0);
            chk_n("slave flag spacing", 24, g);
            gap(g, lv, 1'b1);
            chk_n("slave word spacing", 24, g);
            chk32("received bit", {31'h0, sd}, {31'h0, rx_word_o});
        end
        rd("frame status set", ADDR_IRQ_STATUS, 32'h2, 32'h2);
        summarize();
    end
endmodule : arcc_rx_cfg_tb
